/* File: pkg/sense_pkg.sv */
// Purpose: shared constants and types of the sense/status control block
// Assumes: 25 MHz clock, word-indexed register port with 16-bit data
// Notes:   register indices, field positions and timing counts live here
package sense_pkg;

    // register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // register indices
    localparam logic [ADDR_W-1:0] ADDR_GEN_CFG    = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RETRY_CFG0 = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_RETRY_CFG1 = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_FAULT_STAT = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_STATE_STAT = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 3'h6;

    // general configuration fields
    localparam int BIT_SENSE_SEL0 = 1;
    localparam int BIT_SENSE_SEL1 = 2;
    localparam int BIT_HOLD_EN    = 6;
    // retry configuration field
    localparam int BIT_OFFSET_POS = 8;
    // fault status field
    localparam int BIT_PREWARN    = 8;
    // state status fields, channel x at bit x
    localparam int BIT_OUT0       = 0;

    // interrupt status / mask layout
    localparam int IRQ_N          = 3;
    localparam int IRQ_PREWARN    = 0;
    localparam int IRQ_VALID      = 1;
    localparam int IRQ_SAMPLE     = 2;

    // reset values
    localparam logic [1:0]       RST_SENSE_SEL  = 2'h0;
    localparam logic             RST_HOLD_EN    = 1'h0;
    localparam logic [1:0]       RST_OFFSET_POS = 2'h0;
    localparam logic [IRQ_N-1:0] RST_IRQ_MASK   = 3'h0;

    // sense source select codes {select bit1, select bit0}
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_CH0  = 2'h1;
    localparam logic [1:0] SRC_CH1  = 2'h2;
    localparam logic [1:0] SRC_TEMP = 2'h3;

    // sense code width
    localparam int SENSE_W_DEF = 10;

    // timing: settling after turn-on before the sense code is valid
    localparam int CLK_PERIOD_NS  = 40;
    localparam int SETTLE_TIME_NS = 20000;
    localparam int SETTLE_CYC     =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // sensing sequence, gray coded along idle-settle-valid-held
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SETTLE = 2'h1,
        ST_VALID  = 2'h3,
        ST_HELD   = 2'h2
    } sense_st_t;

endpackage : sense_pkg

/* File: pkg/sense_if.sv */
// Purpose: link between sequence control and the internal hold store
// Assumes: one clock domain
// Notes:   clear beats sample beats track inside the store
`timescale 1ns/1ps
interface sense_if #(
    parameter int SENSE_W = 10
);
    logic [SENSE_W-1:0] live;
    logic               track;
    logic               sample;
    logic               clear;
    logic [SENSE_W-1:0] held;
    logic               frozen;

    modport ctrl  (output live, track, sample, clear, input held, frozen);
    modport store (input live, track, sample, clear, output held, frozen);
endinterface : sense_if

/* File: verilog/sense_hold.sv */
// Purpose: internal sample-and-hold store for the sense code
// Assumes: controller pulses sample at the switch-off instant
// Notes:   held follows live while tracking, freezes on sample
`timescale 1ns/1ps
module sense_hold #(
    parameter int SENSE_W = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // controller side
    sense_if.store   hs
);
    typedef struct packed {
        logic [SENSE_W-1:0] held;
        logic               frozen;
    } hold_state_t;

    hold_state_t s_reg;
    hold_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (hs.clear) begin
            // emptied before the other source is acquired
            s_next.held   = '0;
            s_next.frozen = 1'b0;
        end else if (hs.sample) begin
            s_next.frozen = 1'b1;
        end else if (hs.track) begin
            s_next.held   = hs.live;
            s_next.frozen = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hs.held   = s_reg.held;
    assign hs.frozen = s_reg.frozen;
endmodule : sense_hold

/* File: verilog/current_sense_status_control.sv */
// Purpose: sense routing, track/hold, sense strobe, prewarning and
//          switching state status for a dual high-side switch
// Assumes: all inputs synchronous to clk; analogue sense quantities
//          arrive as digital codes, comparators as levels
// Notes:   registers on a plain word port, read data one cycle later
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - hold mode keeps sense output after switch-off
// - after turn-on valid only after strobe falls
// - switch-off samples last value, strobe goes high
// - changing sensed channel discards held value
// - offset polarity bit D8 selects offset sign
// - held sample keeps polarity active at switch-off
// - normal mode sets prewarning flag over threshold
// - prewarning never switches a channel off
// - prewarning clears on read once temperature dropped
// - state status shows channels above half supply
// - synchronous strobe low from valid until switch-off
// - overcurrent window disables sensing, strobe high
module current_sense_status_control #(
    parameter int SENSE_W    = sense_pkg::SENSE_W_DEF,
    parameter int SETTLE_CYC = sense_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // register port
    input  wire logic [sense_pkg::ADDR_W-1:0] addr,
    input  wire logic [sense_pkg::DATA_W-1:0] wr_data,
    input  wire logic                         wr_stb,
    input  wire logic                         rd_stb,
    output logic      [sense_pkg::DATA_W-1:0] rd_data,
    // channel control and comparators
    input  wire logic [1:0]                   ch_on,
    input  wire logic [1:0]                   out_above_half,
    input  wire logic [1:0]                   oc_window_active,
    input  wire logic                         normal_mode,
    input  wire logic                         temp_above_prewarn,
    // sense quantities
    input  wire logic [1:0][SENSE_W-1:0]      cur_code,
    input  wire logic [SENSE_W-1:0]           temp_code,
    input  wire logic signed [SENSE_W-1:0]    rand_offset,
    // sense output and strobe
    output logic      [SENSE_W-1:0]           sense_code,
    output logic                              sense_drive,
    output logic                              sense_valid_strobe_n,
    // interrupt
    output logic                              irq
);
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYC - 1);
    localparam int DW = sense_pkg::DATA_W;

    typedef struct packed {
        sense_pkg::sense_st_t       st;
        logic [CNT_W-1:0]           cnt;
        logic [1:0]                 on_q;
        logic [1:0]                 sense_sel;
        logic                       hold_en;
        logic [1:0]                 offset_pos;
        logic                       prewarn;
        logic [1:0]                 out_state;
        logic [sense_pkg::IRQ_N-1:0] irq_status;
        logic [sense_pkg::IRQ_N-1:0] irq_mask;
        logic [DW-1:0]              rd_data;
        logic [SENSE_W-1:0]         sense_code;
        logic                       sense_drive;
        logic                       strobe_n;
        logic                       irq;
    } ctrl_state_t;

    ctrl_state_t s_reg;
    ctrl_state_t s_next;

    sense_if #(.SENSE_W(SENSE_W)) hs ();

    sense_hold #(
        .SENSE_W (SENSE_W)
    ) u_hold (
        .clk   (clk),
        .rst_b (rst_b),
        .hs    (hs.store)
    );

    // adds or subtracts the random offset, clamped to the code range
    function automatic logic [SENSE_W-1:0] offset_apply(
        input logic [SENSE_W-1:0]        cur,
        input logic signed [SENSE_W-1:0] off,
        input logic                      pos
    );
        logic signed [SENSE_W+1:0] c;
        logic signed [SENSE_W+1:0] o;
        logic signed [SENSE_W+1:0] sum;
        c   = $signed({2'b00, cur});
        o   = off;
        sum = pos ? (c + o) : (c - o);
        if (sum[SENSE_W+1]) begin
            offset_apply = '0;
        end else if (sum[SENSE_W]) begin
            offset_apply = '1;
        end else begin
            offset_apply = sum[SENSE_W-1:0];
        end
    endfunction : offset_apply

    // per-channel live sense code with its own polarity
    logic [1:0][SENSE_W-1:0] ch_live;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            assign ch_live[gi] = offset_apply(cur_code[gi], rand_offset,
                                              s_reg.offset_pos[gi]);
        end
    endgenerate

    logic                sel_is_ch;
    logic                sel_ch;
    logic                sel_on;
    logic                sel_rise;
    logic                sel_oc;
    logic [SENSE_W-1:0]  live_code;
    logic [1:0]          sel_wr;
    logic                src_change;
    logic                rd_fault;

    always_comb begin
        sel_is_ch = (s_reg.sense_sel == sense_pkg::SRC_CH0) ||
                    (s_reg.sense_sel == sense_pkg::SRC_CH1);
        sel_ch    = (s_reg.sense_sel == sense_pkg::SRC_CH1);
        sel_on    = sel_is_ch && ch_on[sel_ch];
        sel_rise  = sel_on && !s_reg.on_q[sel_ch];
        sel_oc    = sel_is_ch && oc_window_active[sel_ch];
        live_code = ch_live[sel_ch];
        sel_wr    = {wr_data[sense_pkg::BIT_SENSE_SEL1],
                     wr_data[sense_pkg::BIT_SENSE_SEL0]};
        src_change = wr_stb && (addr == sense_pkg::ADDR_GEN_CFG) &&
                     (sel_wr != s_reg.sense_sel);
        rd_fault  = rd_stb && (addr == sense_pkg::ADDR_FAULT_STAT);
    end

    // hold store steering
    always_comb begin
        hs.live   = live_code;
        hs.track  = (s_reg.st == sense_pkg::ST_VALID);
        hs.sample = (s_reg.st == sense_pkg::ST_VALID) && !sel_on &&
                    s_reg.hold_en && !src_change;
        hs.clear  = src_change;
    end

    logic [sense_pkg::IRQ_N-1:0] ev;
    logic                        enter_valid;
    logic                        prewarn_set;

    always_comb begin
        s_next      = s_reg;
        ev          = '0;
        enter_valid = 1'b0;
        s_next.on_q = ch_on;
        s_next.out_state = out_above_half;

        // sensing sequence for the selected channel
        unique case (s_reg.st)
            sense_pkg::ST_IDLE: begin
                s_next.cnt = '0;
                if (sel_rise) begin
                    s_next.st = sense_pkg::ST_SETTLE;
                end
            end
            sense_pkg::ST_SETTLE: begin
                if (!sel_on) begin
                    s_next.st = s_reg.hold_en && hs.frozen ?
                                sense_pkg::ST_HELD : sense_pkg::ST_IDLE;
                end else if (sel_oc) begin
                    s_next.cnt = '0;
                end else if (s_reg.cnt == CNT_LAST) begin
                    s_next.st   = sense_pkg::ST_VALID;
                    enter_valid = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_W'(1);
                end
            end
            sense_pkg::ST_VALID: begin
                if (!sel_on) begin
                    s_next.st = s_reg.hold_en ? sense_pkg::ST_HELD
                                              : sense_pkg::ST_IDLE;
                end else if (sel_oc) begin
                    s_next.st  = sense_pkg::ST_SETTLE;
                    s_next.cnt = '0;
                end
            end
            sense_pkg::ST_HELD: begin
                s_next.cnt = '0;
                if (!s_reg.hold_en) begin
                    s_next.st = sense_pkg::ST_IDLE;
                end else if (sel_rise) begin
                    s_next.st = sense_pkg::ST_SETTLE;
                end
            end
        endcase

        // a new source is re-acquired from a fresh turn-on
        if (src_change) begin
            s_next.st  = sense_pkg::ST_IDLE;
            s_next.cnt = '0;
        end

        // sense output, strobe low only while a valid code is driven
        s_next.strobe_n    = 1'b1;
        s_next.sense_drive = 1'b0;
        s_next.sense_code  = '0;
        if (s_reg.sense_sel == sense_pkg::SRC_TEMP) begin
            s_next.sense_drive = 1'b1;
            s_next.sense_code  = temp_code;
        end else if (s_next.st == sense_pkg::ST_VALID) begin
            s_next.strobe_n    = 1'b0;
            s_next.sense_drive = 1'b1;
            s_next.sense_code  = live_code;
        end else if (s_next.st == sense_pkg::ST_HELD) begin
            s_next.sense_drive = 1'b1;
            s_next.sense_code  = hs.frozen ? hs.held : live_code;
        end
        if (sel_oc) begin
            s_next.strobe_n    = 1'b1;
            s_next.sense_drive = 1'b0;
            s_next.sense_code  = '0;
        end

        // prewarning flag, set wins over clear-on-read
        prewarn_set    = normal_mode && temp_above_prewarn;
        s_next.prewarn = prewarn_set ||
                         (s_reg.prewarn &&
                          !(rd_fault && !temp_above_prewarn));

        // register writes
        if (wr_stb) begin
            unique case (addr)
                sense_pkg::ADDR_GEN_CFG: begin
                    s_next.sense_sel = sel_wr;
                    s_next.hold_en   = wr_data[sense_pkg::BIT_HOLD_EN];
                end
                sense_pkg::ADDR_RETRY_CFG0: begin
                    s_next.offset_pos[0] =
                        wr_data[sense_pkg::BIT_OFFSET_POS];
                end
                sense_pkg::ADDR_RETRY_CFG1: begin
                    s_next.offset_pos[1] =
                        wr_data[sense_pkg::BIT_OFFSET_POS];
                end
                sense_pkg::ADDR_IRQ_STATUS: begin
                    s_next.irq_status = s_reg.irq_status &
                                        ~wr_data[sense_pkg::IRQ_N-1:0];
                end
                sense_pkg::ADDR_IRQ_MASK: begin
                    s_next.irq_mask = wr_data[sense_pkg::IRQ_N-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky events, set after clear so the set wins
        ev[sense_pkg::IRQ_PREWARN] = prewarn_set && !s_reg.prewarn;
        ev[sense_pkg::IRQ_VALID]   = enter_valid;
        ev[sense_pkg::IRQ_SAMPLE]  = hs.sample;
        s_next.irq_status = s_next.irq_status | ev;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);

        // read data, one cycle after the strobe, zero otherwise
        s_next.rd_data = '0;
        if (rd_stb) begin
            unique case (addr)
                sense_pkg::ADDR_GEN_CFG: begin
                    s_next.rd_data[sense_pkg::BIT_SENSE_SEL0] =
                        s_reg.sense_sel[0];
                    s_next.rd_data[sense_pkg::BIT_SENSE_SEL1] =
                        s_reg.sense_sel[1];
                    s_next.rd_data[sense_pkg::BIT_HOLD_EN] = s_reg.hold_en;
                end
                sense_pkg::ADDR_RETRY_CFG0: begin
                    s_next.rd_data[sense_pkg::BIT_OFFSET_POS] =
                        s_reg.offset_pos[0];
                end
                sense_pkg::ADDR_RETRY_CFG1: begin
                    s_next.rd_data[sense_pkg::BIT_OFFSET_POS] =
                        s_reg.offset_pos[1];
                end
                sense_pkg::ADDR_FAULT_STAT: begin
                    s_next.rd_data[sense_pkg::BIT_PREWARN] = s_reg.prewarn;
                end
                sense_pkg::ADDR_STATE_STAT: begin
                    s_next.rd_data[sense_pkg::BIT_OUT0 +: 2] =
                        s_reg.out_state;
                end
                sense_pkg::ADDR_IRQ_STATUS: begin
                    s_next.rd_data[sense_pkg::IRQ_N-1:0] = s_reg.irq_status;
                end
                sense_pkg::ADDR_IRQ_MASK: begin
                    s_next.rd_data[sense_pkg::IRQ_N-1:0] = s_reg.irq_mask;
                end
                default: begin
                end
            endcase
        end
    end

    // no path from the prewarning flag reaches channel control
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg            <= '0;
            s_reg.st         <= sense_pkg::ST_IDLE;
            s_reg.sense_sel  <= sense_pkg::RST_SENSE_SEL;
            s_reg.hold_en    <= sense_pkg::RST_HOLD_EN;
            s_reg.offset_pos <= sense_pkg::RST_OFFSET_POS;
            s_reg.irq_mask   <= sense_pkg::RST_IRQ_MASK;
            s_reg.strobe_n   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data              = s_reg.rd_data;
    assign sense_code           = s_reg.sense_code;
    assign sense_drive          = s_reg.sense_drive;
    assign sense_valid_strobe_n = s_reg.strobe_n;
    assign irq                  = s_reg.irq;
endmodule : current_sense_status_control

/* File: sim/sense_checks_assertions.sv */
// Purpose: port checks of the sense/status block
// Assumes: one clock, synchronous reset
// Notes:   bound into current_sense_status_control
`timescale 1ns/1ps
module sense_checks #(
    parameter int SENSE_W    = 10,
    parameter int SETTLE_CYC = 500
) (
    // clock and reset
    input wire logic                         clk,
    input wire logic                         rst_b,
    // register port
    input wire logic [sense_pkg::ADDR_W-1:0] addr,
    input wire logic                         rd_stb,
    input wire logic [sense_pkg::DATA_W-1:0] rd_data,
    // channel side
    input wire logic [1:0]                   ch_on,
    input wire logic [1:0]                   out_above_half,
    input wire logic [1:0]                   oc_window_active,
    input wire logic                         normal_mode,
    input wire logic                         temp_above_prewarn,
    // sense output
    input wire logic [SENSE_W-1:0]           sense_code,
    input wire logic                         sense_drive,
    input wire logic                         sense_valid_strobe_n
);
    // cycles some channel has been on
    logic [15:0] on_cnt_reg;
    always_ff @(posedge clk) begin
        if (!rst_b || ch_on == 2'h0) begin
            on_cnt_reg <= 16'h0000;
        end else if (on_cnt_reg != 16'hFFFF) begin
            on_cnt_reg <= on_cnt_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_settle_before_valid: assert property (
        $fell(sense_valid_strobe_n) |-> on_cnt_reg >= SETTLE_CYC)
        else $error("strobe fell before settling");
    a_off_raises_strobe: assert property (
        ch_on == 2'h0 |=> sense_valid_strobe_n)
        else $error("strobe low, all off");
    a_valid_needs_drive: assert property (
        !sense_valid_strobe_n |-> sense_drive)
        else $error("strobe low, undriven");
    a_oc_blocks_strobe: assert property (
        |oc_window_active |=> sense_valid_strobe_n)
        else $error("strobe low in window");
    a_undriven_code_zero: assert property (
        !sense_drive |-> sense_code == '0)
        else $error("code while undriven");
    a_state_bits_read: assert property (
        rd_stb && addr == sense_pkg::ADDR_STATE_STAT && $past(rst_b)
        && $stable(out_above_half) |=> rd_data[1:0] == $past(out_above_half))
        else $error("state bits wrong");
    a_prewarn_sets_flag: assert property (
        rd_stb && addr == sense_pkg::ADDR_FAULT_STAT && $past(rst_b)
        && $past(normal_mode && temp_above_prewarn) |=> rd_data[8])
        else $error("prewarning flag missing");
    a_prewarn_read_clears: assert property (
        rd_stb && addr == sense_pkg::ADDR_FAULT_STAT && !temp_above_prewarn
        ##1 !temp_above_prewarn ##1 rd_stb && !temp_above_prewarn
        && addr == sense_pkg::ADDR_FAULT_STAT |=> !rd_data[8])
        else $error("prewarning kept");
endmodule : sense_checks

bind current_sense_status_control sense_checks #(
    .SENSE_W(SENSE_W), .SETTLE_CYC(SETTLE_CYC)
) chk_u (.*);

/* File: sim/host_adc.sv */
// Purpose: host converter reading the sense output
// Assumes: converts only while the strobe is low
// Notes:   keeps the last valid conversion
`timescale 1ns/1ps
module host_adc #(
    parameter int SENSE_W = 10
) (
    // clock
    input wire logic               clk,
    // sense output of the block
    input wire logic [SENSE_W-1:0] sense_code,
    input wire logic               sense_drive,
    input wire logic               sense_valid_strobe_n,
    // converted value
    output logic     [SENSE_W-1:0] reading
);
    always_ff @(posedge clk) begin
        if (!sense_valid_strobe_n && sense_drive) begin
            reading <= sense_code;
        end
    end
endmodule : host_adc

/* File: sim/tb_top.sv */
// Purpose: self-checking bench of the sense/status block
// Assumes: short settle count
// Notes:   expectations from an integer sense model
`timescale 1ns/1ps
module tb_top;
    localparam int STL = 4;
    logic                         clk, rst_b, wr_stb, rd_stb, irq;
    logic [sense_pkg::ADDR_W-1:0] addr;
    logic [15:0]                  wr_data, rd_data, d;
    logic [1:0]                   ch_on, out_above_half, oc_window_active;
    logic                         normal_mode, temp_above_prewarn;
    logic [1:0][9:0]              cur_code;
    logic [9:0]                   temp_code, sense_code, reading;
    logic signed [9:0]            rand_offset;
    logic                         sense_drive, sense_valid_strobe_n;
    logic [31:0]                  seed;
    int                           bad_count, cmp_count, n, off, tmp;
    int                           cc[2];
    int                           meas[$];

    current_sense_status_control #(.SENSE_W(10), .SETTLE_CYC(STL)) dut_u (.*);
    host_adc #(.SENSE_W(10)) adc_u (.*);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // offset code, clamped
    function automatic int live(input int c, input int o, input bit p);
        int v;
        v = p ? c + o : c - o;
        return v < 0 ? 0 : (v > 1023 ? 1023 : v);
    endfunction : live
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 v = rd_data;
    endtask : rd
    task automatic wait_low();
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (sense_valid_strobe_n !== 1'b0 && n < 40);
    endtask : wait_low
    task automatic turn_on(input int ch);
        @(posedge clk);
        ch_on[ch] <= 1'b1;
        wait_low();
    endtask : turn_on
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        {rst_b, wr_stb, rd_stb, normal_mode, temp_above_prewarn} = '0;
        {addr, wr_data, ch_on, out_above_half, oc_window_active} = '0;
        {cur_code, temp_code, rand_offset} = '0;
        bad_count = 0;
        cmp_count = 0;
        seed = 32'h000110D1;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(3'h7, d);
        chk("unmapped", d, 16'h0000);
        for (int v = 0; v < 4; v++) begin
            @(posedge clk);
            out_above_half <= 2'(v);
            settle(2);
            rd(sense_pkg::ADDR_STATE_STAT, d);
            chk("state", d, 16'(v));
        end
        // hold mode, fast toggling
        cc[0] = 200 + int'(rnd() % 512);
        off = int'(rnd() % 128) - 64;
        @(posedge clk);
        cur_code[0] <= 10'(cc[0]);
        rand_offset <= 10'(off);
        wr(sense_pkg::ADDR_GEN_CFG, 16'h0042);
        for (int p = 1; p >= 0; p--) begin
            wr(sense_pkg::ADDR_RETRY_CFG0, p ? 16'h0100 : 16'h0000);
            turn_on(0);
            chk("settle", 16'(n), 16'(STL + 1));
            chk("live", sense_code, 16'(live(cc[0], off, p)));
            @(posedge clk);
            ch_on[0] <= 1'b0;
            settle(3);
            chk("held strobe", sense_valid_strobe_n, 1'b1);
            chk("held drive", sense_drive, 1'b1);
            chk("held code", sense_code, 16'(live(cc[0], off, p)));
            meas.push_back(int'(reading));
        end
        wr(sense_pkg::ADDR_RETRY_CFG0, 16'h0100);
        settle(2);
        chk("held after flip", sense_code, 16'(live(cc[0], off, 0)));
        chk("averaged", 16'((meas[0] + meas[1]) / 2), 16'(cc[0]));
        wr(sense_pkg::ADDR_GEN_CFG, 16'h0044);
        settle(2);
        chk("moved drive", sense_drive, 1'b0);
        // synchronous mode, each channel
        for (int ch = 0; ch < 2; ch++) begin
            cc[ch] = int'(rnd() % 1024);
            @(posedge clk);
            cur_code[ch] <= 10'(cc[ch]);
            wr(sense_pkg::ADDR_GEN_CFG, ch ? 16'h0004 : 16'h0002);
            turn_on(ch);
            chk("sync code", sense_code, 16'(live(cc[ch], off, ch == 0)));
            @(posedge clk);
            oc_window_active[ch] <= 1'b1;
            settle(2);
            chk("oc strobe", sense_valid_strobe_n, 1'b1);
            chk("oc drive", sense_drive, 1'b0);
            @(posedge clk);
            oc_window_active[ch] <= 1'b0;
            wait_low();
            chk("oc retry", sense_valid_strobe_n, 1'b0);
            @(posedge clk);
            ch_on[ch] <= 1'b0;
            settle(2);
            chk("sync strobe", sense_valid_strobe_n, 1'b1);
            chk("sync drive", sense_drive, 1'b0);
        end
        tmp = int'(rnd() % 1024);
        @(posedge clk);
        temp_code <= 10'(tmp);
        wr(sense_pkg::ADDR_GEN_CFG, 16'h0046);
        settle(3);
        chk("temp drive", sense_drive, 1'b1);
        chk("temp code", sense_code, 16'(tmp));
        chk("temp strobe", sense_valid_strobe_n, 1'b1);
        // current again after a turn-on
        wr(sense_pkg::ADDR_GEN_CFG, 16'h0042);
        turn_on(0);
        chk("after temp", sense_code, 16'(live(cc[0], off, 1)));
        @(posedge clk);
        ch_on[0] <= 1'b0;
        // prewarning and its interrupt
        wr(sense_pkg::ADDR_IRQ_MASK, 16'h0001);
        @(posedge clk);
        normal_mode <= 1'b1;
        temp_above_prewarn <= 1'b1;
        settle(3);
        chk("irq raised", irq, 1'b1);
        rd(sense_pkg::ADDR_FAULT_STAT, d);
        chk("prewarn", d[8], 1'b1);
        rd(sense_pkg::ADDR_FAULT_STAT, d);
        chk("prewarn kept", d[8], 1'b1);
        rd(sense_pkg::ADDR_STATE_STAT, d);
        chk("channels kept", d[1:0], out_above_half);
        wr(sense_pkg::ADDR_IRQ_MASK, 16'h0000);
        settle(2);
        chk("irq masked", irq, 1'b0);
        wr(sense_pkg::ADDR_IRQ_MASK, 16'h0001);
        settle(2);
        chk("irq unmasked", irq, 1'b1);
        @(posedge clk);
        temp_above_prewarn <= 1'b0;
        rd(sense_pkg::ADDR_FAULT_STAT, d);
        chk("prewarn last", d[8], 1'b1);
        rd(sense_pkg::ADDR_FAULT_STAT, d);
        chk("prewarn cleared", d[8], 1'b0);
        wr(sense_pkg::ADDR_IRQ_STATUS, 16'h0007);
        settle(2);
        chk("irq cleared", irq, 1'b0);
        rd(sense_pkg::ADDR_IRQ_STATUS, d);
        chk("status cleared", d[0], 1'b0);
        end_sim();
    end
endmodule : tb_top
